// ===== hw/dio8_port.sv
`timescale 1ns/100ps
`default_nettype none
`include "dio8_defs.svh"

// Contract
// - eight-bit direction word; one makes a line output, zero input
// - level query returns one bit per line: high reads one, low zero
// - bits of output lines read as zero in the level word
// - output lines driven high for one, low for zero
// - level bits of input lines have no effect on any pin
// - bits 0-3 map to lines 1-4, bits 4-7 to lines 6-9
module dio8_port (
  // clock and reset
  input  wire logic                 mclk_i,
  input  wire logic                 rst_i,
  // command side
  input  wire logic                 dir_we_i,
  input  wire dio8_pkg::dio8_word_t dir_wdata_i,
  input  wire logic                 lvl_we_i,
  input  wire dio8_pkg::dio8_word_t lvl_wdata_i,
  // status side
  output var  dio8_pkg::dio8_word_t dir_o,
  output var  dio8_pkg::dio8_word_t in_level_o,
  // connector lines 1-4, 6-9 (pin 5 ground)
  input  wire dio8_pkg::dio8_word_t pin_in_i,
  output var  dio8_pkg::dio8_word_t pin_out_o,
  output var  dio8_pkg::dio8_word_t pin_oe_o
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    dio8_pkg::dio8_ctl_s ctl;
    dio8_pkg::dio8_pad_s pad;
  } dio8_st_s;

  dio8_st_s st_q;
  dio8_st_s st_d;

  // ****************************************************************
  // helpers
  // ****************************************************************
  // stored level bits reach a pad only while the line is an output
  function automatic dio8_pkg::dio8_word_t drive_word(
    input dio8_pkg::dio8_word_t level,
    input dio8_pkg::dio8_word_t dir
  );
    return level & dir;
  endfunction : drive_word

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    st_d = st_q;
    if (dir_we_i) begin
      st_d.ctl.dir = dir_wdata_i;
    end
    if (lvl_we_i) begin
      st_d.ctl.level = lvl_wdata_i;
    end
    // pads follow the updated words, bit i on line order
    st_d.pad.oe   = st_d.ctl.dir;
    // stored input-line bits stay harmless: masked at the pad
    // a later direction write drives level bits stored earlier
    st_d.pad.dout = drive_word(st_d.ctl.level, st_d.ctl.dir);
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q.ctl.dir   <= `DIO8_DIR_RST;
      st_q.ctl.level <= `DIO8_LEVEL_RST;
      st_q.pad.oe    <= `DIO8_DIR_RST;
      st_q.pad.dout  <= `DIO8_LEVEL_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign dir_o     = st_q.ctl.dir;
  assign pin_oe_o  = st_q.pad.oe;
  assign pin_out_o = st_q.pad.dout;

  // ****************************************************************
  // input sampling
  // ****************************************************************
  // next-state direction, so the read mask never lags dir_o a cycle
  dio8_sample dio8_sample_i (
    .mclk_i   (mclk_i),
    .rst_i    (rst_i),
    .pad_in_i (pin_in_i),
    .dir_i    (st_d.ctl.dir),
    .level_o  (in_level_o)
  );

  // ****************************************************************
  // write checks
  // ****************************************************************
  property p_dir_wr;
    @(posedge mclk_i) disable iff (rst_i)
    dir_we_i |=> (pin_oe_o == $past(dir_wdata_i));
  endproperty
  a_dir_wr: assert property (p_dir_wr)
    else $error("direction write not applied");

  property p_drive;
    @(posedge mclk_i) disable iff (rst_i)
    (lvl_we_i && !dir_we_i) |=>
      (pin_out_o == ($past(lvl_wdata_i) & pin_oe_o));
  endproperty
  a_drive: assert property (p_drive)
    else $error("output level not driven");

  property p_in_ignored;
    @(posedge mclk_i) disable iff (rst_i)
    ((pin_out_o & ~pin_oe_o) == `DIO8_ALL_IN);
  endproperty
  a_in_ignored: assert property (p_in_ignored)
    else $error("input line carries drive data");

  property p_oe_dir;
    @(posedge mclk_i) disable iff (rst_i)
    (pin_oe_o == dir_o);
  endproperty
  a_oe_dir: assert property (p_oe_dir)
    else $error("pad enable differs from direction");

  property p_drive_both;
    @(posedge mclk_i) disable iff (rst_i)
    (lvl_we_i && dir_we_i) |=>
      (pin_out_o == ($past(lvl_wdata_i) & $past(dir_wdata_i)));
  endproperty
  a_drive_both: assert property (p_drive_both)
    else $error("joint write not driven");

  property p_out_hold;
    @(posedge mclk_i) disable iff (rst_i)
    (!lvl_we_i && !dir_we_i) |=> $stable(pin_out_o);
  endproperty
  a_out_hold: assert property (p_out_hold)
    else $error("drive changed without write");

  property p_keep_level;
    @(posedge mclk_i) disable iff (rst_i)
    (dir_we_i && !lvl_we_i) |=>
      (pin_out_o == drive_word($past(st_q.ctl.level), pin_oe_o));
  endproperty
  a_keep_level: assert property (p_keep_level)
    else $error("stored level lost on direction write");

  // ****************************************************************
  // read checks
  // ****************************************************************
  property p_read;
    @(posedge mclk_i) disable iff (rst_i)
    1'b1 |=>
      (in_level_o == ($past(pin_in_i) & ~dir_o));
  endproperty
  a_read: assert property (p_read)
    else $error("level word wrong");

  // must hold in the very cycle a line turns into an output
  property p_in_masked;
    @(posedge mclk_i) disable iff (rst_i)
    ((in_level_o & dir_o) == `DIO8_ALL_IN);
  endproperty
  a_in_masked: assert property (p_in_masked)
    else $error("output line reads as high");

  property p_turn_out;
    @(posedge mclk_i) disable iff (rst_i)
    dir_we_i |=> ((in_level_o & $past(dir_wdata_i)) == `DIO8_ALL_IN);
  endproperty
  a_turn_out: assert property (p_turn_out)
    else $error("new output line still reads its level");

  property p_read_in;
    @(posedge mclk_i) disable iff (rst_i)
    (dir_o == `DIO8_ALL_IN && !dir_we_i) |=>
      (in_level_o == $past(pin_in_i));
  endproperty
  a_read_in: assert property (p_read_in)
    else $error("input line level not returned");

  // ****************************************************************
  // reset and direction-hold checks
  // ****************************************************************

  property p_reset;
    @(posedge mclk_i)
    $fell(rst_i) |-> (dir_o == `DIO8_DIR_RST && pin_oe_o == `DIO8_DIR_RST
      && pin_out_o == `DIO8_LEVEL_RST && in_level_o == `DIO8_LEVEL_RST);
  endproperty
  a_reset: assert property (p_reset)
    else $error("reset state wrong");

  // reset is asynchronous: the port is clear by the next edge
  property p_rst_clear;
    @(posedge mclk_i)
    $rose(rst_i) |-> (dir_o == `DIO8_DIR_RST && pin_oe_o == `DIO8_DIR_RST
      && pin_out_o == `DIO8_LEVEL_RST && in_level_o == `DIO8_LEVEL_RST);
  endproperty
  a_rst_clear: assert property (p_rst_clear)
    else $error("reset did not clear the port");

  property p_hold;
    @(posedge mclk_i) disable iff (rst_i)
    !dir_we_i |=> $stable(dir_o);
  endproperty
  a_hold: assert property (p_hold)
    else $error("direction changed without write");

endmodule : dio8_port

`default_nettype wire

// ===== include/dio8_defs.svh
`ifndef DIO8_DEFS_SVH
`define DIO8_DEFS_SVH

// ****************************************************************
// widths and reset values
// ****************************************************************
`define DIO8_WIDTH      8
`define DIO8_DIR_RST    8'h00
`define DIO8_LEVEL_RST  8'h00
`define DIO8_ALL_IN     8'h00

`endif

// ===== include/dio8_pkg.sv
package dio8_pkg;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef logic [7:0] dio8_word_t;

  // one connector image: bit i is word bit i, lines 1-4 then 6-9
  typedef struct packed {
    dio8_word_t dir;
    dio8_word_t level;
  } dio8_ctl_s;

  typedef struct packed {
    dio8_word_t oe;
    dio8_word_t dout;
  } dio8_pad_s;

endpackage : dio8_pkg

// ===== hw/dio8_sample.sv
`timescale 1ns/100ps
`default_nettype none
`include "dio8_defs.svh"

// registers pad levels and masks out output lines
module dio8_sample (
  // clock and reset
  input  wire logic                mclk_i,
  input  wire logic                rst_i,
  // pad side
  input  wire dio8_pkg::dio8_word_t pad_in_i,
  input  wire dio8_pkg::dio8_word_t dir_i,
  // result
  output var  dio8_pkg::dio8_word_t level_o
);

  typedef struct packed {
    dio8_pkg::dio8_word_t level;
  } dio8_smp_s;

  dio8_smp_s st_q;
  dio8_smp_s st_d;

  always_comb begin
    st_d       = st_q;
    st_d.level = pad_in_i & ~dir_i;
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q.level <= `DIO8_LEVEL_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign level_o = st_q.level;

  property p_out_masked;
    @(posedge mclk_i) disable iff (rst_i)
    ##1 ((level_o & $past(dir_i)) == `DIO8_ALL_IN);
  endproperty
  a_out_masked: assert property (p_out_masked)
    else $error("output line shows a level bit");

endmodule : dio8_sample

`default_nettype wire

// ===== dv/dio8_ext.sv
`timescale 1ns/100ps
`default_nettype none

// far-side equipment: a driven line reads back the port's own level
module dio8_ext (
  // equipment levels
  input  wire logic [7:0] ext_i,
  // port drive
  input  wire logic [7:0] out_i,
  input  wire logic [7:0] oe_i,
  // resolved wire
  output logic      [7:0] pin_o
);
  assign pin_o = (out_i & oe_i) | (ext_i & ~oe_i);
endmodule : dio8_ext

`default_nettype wire

// ===== dv/eight_bit_digital_io_port_test.sv
`timescale 1ns/100ps
`default_nettype none

`define CHK(a, b) begin compares++; if ((a) !== (b)) begin errors++; \
  $display("ERROR t=%0t got %h exp %h", $time, a, b); end end

module eight_bit_digital_io_port_test;
  logic       mclk_i = 0, rst_i = 1, dwe = 0, lwe = 0;
  logic [7:0] dwd = 0, lwd = 0, ext = 0;
  logic [7:0] pin, dir, lvl, out, oe;
  int         errors = 0, compares = 0, cyc = 0;

  always #2 mclk_i = ~mclk_i;

  dio8_port dio8_port_i (.mclk_i(mclk_i), .rst_i(rst_i), .dir_we_i(dwe),
    .dir_wdata_i(dwd), .lvl_we_i(lwe), .lvl_wdata_i(lwd), .dir_o(dir),
    .in_level_o(lvl), .pin_in_i(pin), .pin_out_o(out), .pin_oe_o(oe));
  dio8_ext dio8_ext_i (.ext_i(ext), .out_i(out), .oe_i(oe), .pin_o(pin));

  // ************************************************************
  // tasks
  // ************************************************************
  task automatic drive(input logic dw, input logic [7:0] dv,
                       input logic lw, input logic [7:0] lv);
    @(posedge mclk_i);
    dwe <= dw;
    dwd <= dv;
    lwe <= lw;
    lwd <= lv;
    @(posedge mclk_i);
    dwe <= 1'b0;
    lwe <= 1'b0;
    #1;
  endtask : drive

  // level word lags the wire by one sample
  task automatic settle(input logic [7:0] e);
    @(posedge mclk_i);
    ext <= e;
    repeat (2) @(posedge mclk_i);
    #1;
  endtask : settle

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset_state;
    repeat (3) @(posedge mclk_i);
    rst_i <= 1'b0;
    #1;
    `CHK({dir, oe, out, lvl}, 32'h0000_0000)
  endtask : t_reset_state

  task automatic t_dir_write;
    drive(1'b1, 8'hd4, 1'b0, 8'h00);
    `CHK(dir, 8'hd4)
    `CHK(oe, 8'hd4)
    drive(1'b1, 8'h54, 1'b0, 8'h00);
    `CHK(oe, 8'h54)
  endtask : t_dir_write

  task automatic t_out_drive;
    drive(1'b0, 8'h00, 1'b1, 8'h44);
    `CHK(out, 8'h44)
    drive(1'b0, 8'h00, 1'b1, 8'hff);
    `CHK(out, 8'h54)
  endtask : t_out_drive

  task automatic t_out_masked;
    settle(8'hff);
    `CHK(lvl, 8'hab)
  endtask : t_out_masked

  task automatic t_in_read;
    drive(1'b1, 8'h00, 1'b0, 8'h00);
    `CHK(oe, 8'h00)
    `CHK(out, 8'h00)
    settle(8'h03);
    `CHK(lvl, 8'h03)
  endtask : t_in_read

  task automatic t_line_map;
    for (int i = 0; i < 8; i++) begin
      settle(8'h01 << i);
      `CHK(lvl, 8'h01 << i)
    end
  endtask : t_line_map

  // a line turned to output must read zero at once
  task automatic t_turn_out;
    settle(8'hff);
    `CHK(lvl, 8'hff)
    drive(1'b1, 8'h0f, 1'b0, 8'h00);
    `CHK(dir, 8'h0f)
    `CHK(lvl, 8'hf0)
  endtask : t_turn_out

  task automatic t_joint_write;
    drive(1'b1, 8'hf0, 1'b1, 8'ha5);
    `CHK(dir, 8'hf0)
    `CHK(out, 8'ha0)
    `CHK(lvl, 8'h0f)
  endtask : t_joint_write

  task automatic t_mid_reset;
    @(posedge mclk_i);
    rst_i <= 1'b1;
    #1;
    `CHK({dir, oe, out, lvl}, 32'h0000_0000)
    repeat (3) @(posedge mclk_i);
    rst_i <= 1'b0;
    #1;
    `CHK({dir, oe, out, lvl}, 32'h0000_0000)
    drive(1'b1, 8'h03, 1'b1, 8'h01);
    `CHK(out, 8'h01)
    `CHK(oe, 8'h03)
  endtask : t_mid_reset

  task automatic give_verdict;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : give_verdict

  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 400) begin
      errors++;
      give_verdict();
    end
  end

  // ************************************************************
  // scenarios
  // ************************************************************
  initial begin
    t_reset_state();
    t_dir_write();
    t_out_drive();
    t_out_masked();
    t_in_read();
    t_line_map();
    t_turn_out();
    t_joint_write();
    t_mid_reset();
    give_verdict();
  end
endmodule : eight_bit_digital_io_port_test

`default_nettype wire
